// ---- shared/epi_pkg.sv ----
// package: constants, types and helpers of the external pin interrupt unit
//
// Contract
// R1 - inputs raise requests even while the pin is driven as an output
// R2 - level mode requests for as long as the pin stays low
// R3 - edge detection runs only while the i/o clock runs
// R4 - low level detection works without any clock, for wake-up
// R5 - deep sleep stops the i/o clock, so only level sensing wakes
// R6 - wake needs the low level on two consecutive watchdog clock edges
// R7 - level gone before start-up ends: wake, but no request
// R8 - source holds the level until wake-up has completed
// R9 - request taken only with global enable and input enable set
// R10 - pins are sampled into registers; edges come from the samples
// R11 - edge pulses from the source last longer than one clock
// R12 - source holds low level until the current instruction completes
// R13 - input 1 sense field at bits 3:2, low/change/fall/rise
// R14 - input 0 sense field at bits 1:0, same encodings
// R15 - input enables at bit 7 (input 1) and bit 6 (input 0)
// R16 - event sets pending flag; vector or write of one clears it
// R17 - pending flag reads cleared while level sensing is selected
// R18 - any change compares current sample with the previous one
package epi_pkg;

  // register byte offsets
  localparam logic [7:0] SENSE_OFS   = 8'h00;
  localparam logic [7:0] ENABLE_OFS  = 8'h04;
  localparam logic [7:0] FLAG_OFS    = 8'h08;
  localparam logic [7:0] GLOBAL_OFS  = 8'h0c;
  localparam logic [7:0] CLEAR_OFS   = 8'h10;

  // field positions
  localparam int SENSE1_POS  = 2;
  localparam int SENSE0_POS  = 0;
  localparam int EN1_POS     = 7;
  localparam int EN0_POS     = 6;
  localparam int GIE_POS     = 7;

  // values after reset
  localparam logic [3:0] SENSE_RST  = 4'h0;
  localparam logic [1:0] EN_RST     = 2'h0;
  localparam logic       GIE_RST    = 1'b0;
  localparam logic [1:0] PIN_RST    = 2'h3;

  // timing
  localparam int CLK_MHZ         = 50;
  localparam int WDT_PERIOD_NS   = 1000;
  localparam int WDT_PERIOD_CYC  = (WDT_PERIOD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [15:0] STARTUP_CYC = 16'h0040;

  typedef enum logic [1:0] {
    SENSE_LOW    = 2'b00,
    SENSE_CHANGE = 2'b01,
    SENSE_FALL   = 2'b10,
    SENSE_RISE   = 2'b11
  } epi_sense_e;

  typedef enum logic [2:0] {
    WK_RUN     = 3'b001,
    WK_CONFIRM = 3'b010,
    WK_START   = 3'b100
  } epi_wake_e;

  typedef struct packed {
    epi_sense_e sense1;
    epi_sense_e sense0;
  } epi_cfg_s;

  // edge hit from registered samples
  function automatic logic sense_hit(
    input epi_sense_e mode,
    input logic       cur,
    input logic       prev
  );
    case (mode)
      SENSE_CHANGE: sense_hit = cur ^ prev;
      SENSE_FALL:   sense_hit = prev & ~cur;
      SENSE_RISE:   sense_hit = cur & ~prev;
      default:      sense_hit = 1'b0;
    endcase
  endfunction

endpackage

// ---- logic/epi_top.sv ----
// external pin interrupt unit with apb register slave
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module epi_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq_in_0,
  input  wire logic        ext_irq_in_1,
  input  wire logic        io_clk_run,
  input  wire logic        deep_sleep,
  input  wire logic        wdt_clk_in,
  input  wire logic [1:0]  vector_ack,
  output logic [1:0]       irq_req,
  output logic             irq,
  output logic             level_wake_async,
  output logic             cpu_wake,
  output logic             wake_done
);

  // configuration and status
  epi_pkg::epi_cfg_s interrupt_sense_control;
  logic [1:0]        general_irq_enable_reg;
  logic              core_status_reg;
  logic              ext_pending_flag_0;
  logic              ext_pending_flag_1;

  // synchronisers and samples
  logic [1:0] pin_meta;
  logic [1:0] pin_smp;
  logic [1:0] pin_prev;
  logic       io_meta;
  logic       io_run;
  logic       wdt_meta;
  logic       wdt_smp;
  logic       wdt_prev;
  logic       wdt_edge;

  // wake sequencing
  epi_pkg::epi_wake_e wake_state;
  epi_pkg::epi_wake_e next_wake_state;
  logic [15:0]        start_cnt;

  // bus decode
  logic       setup_ph;
  logic       wr_acc;
  logic       addr_ok;
  logic [1:0] wr_clear;
  logic [1:0] lvl_mode;
  logic [1:0] hit;
  logic [1:0] lvl_low;
  logic [1:0] raw_low;
  logic       lvl_any;
  logic       lvl_mask;
  logic [1:0] pend_rd;

  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  // no wait states: every register answers in its first access cycle
  assign pready   = 1'b1;

  // register write strobe, shared by every writable offset
  function automatic logic wr_sel(
    input logic       acc,
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    wr_sel = acc && (addr == ofs);
  endfunction

  always_comb begin
    case (paddr)
      epi_pkg::SENSE_OFS:  addr_ok = 1'b1;
      epi_pkg::ENABLE_OFS: addr_ok = 1'b1;
      epi_pkg::FLAG_OFS:   addr_ok = 1'b1;
      epi_pkg::GLOBAL_OFS: addr_ok = 1'b1;
      epi_pkg::CLEAR_OFS:  addr_ok = 1'b1;
      default:             addr_ok = 1'b0;
    endcase
  end

  // unmapped offsets answer with an error; writes there are dropped
  assign pslverr = psel & penable & ~addr_ok;

  // pin samples through two flops; edges read only stage two
  always_ff @(posedge pclk or negedge presetn) begin
    // idle level of the pins, so no false edge follows reset
    if (!presetn) begin
      pin_meta <= epi_pkg::PIN_RST;
      pin_smp  <= epi_pkg::PIN_RST;
    end else begin
      pin_meta <= {ext_irq_in_1, ext_irq_in_0}; // [R1] [R10]
      pin_smp  <= pin_meta; // [R10]
    end
  end

  // previous sample only moves while the i/o clock runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= epi_pkg::PIN_RST;
    end else if (io_run) begin
      pin_prev <= pin_smp; // [R3] [R18]
    end
  end

  // i/o clock presence comes from another domain, two flops like a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_meta <= 1'b0;
      io_run  <= 1'b0;
    end else begin
      io_meta <= io_clk_run;
      io_run  <= io_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_meta <= 1'b0;
      wdt_smp  <= 1'b0;
    end else begin
      wdt_meta <= wdt_clk_in;
      wdt_smp  <= wdt_meta;
    end
  end

  // edge of the watchdog clock, taken from the synchronised copy only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_prev <= 1'b0;
    end else begin
      wdt_prev <= wdt_smp; // [R6]
    end
  end

  assign wdt_edge = wdt_smp & ~wdt_prev;

  // sense decode per input
  assign lvl_mode[0] =
    (interrupt_sense_control.sense0 == epi_pkg::SENSE_LOW); // [R14]
  assign lvl_mode[1] =
    (interrupt_sense_control.sense1 == epi_pkg::SENSE_LOW); // [R13]

  // edge hits only while the i/o clock runs; deep sleep stops it
  assign hit[0] = io_run & epi_pkg::sense_hit(
    interrupt_sense_control.sense0, pin_smp[0], pin_prev[0]); // [R3] [R5]
  assign hit[1] = io_run & epi_pkg::sense_hit(
    interrupt_sense_control.sense1, pin_smp[1], pin_prev[1]); // [R3] [R5]

  assign lvl_low = general_irq_enable_reg & lvl_mode & ~pin_smp; // [R2]
  assign lvl_any = |lvl_low;

  // clockless path: raw pin straight to the wake request
  assign raw_low = ~{ext_irq_in_1, ext_irq_in_0};
  assign level_wake_async =
    |(general_irq_enable_reg & lvl_mode & raw_low); // [R4] [R5]

  // write-one clears from either flag or clear register
  always_comb begin
    wr_clear = vector_ack;
    if (wr_sel(wr_acc, paddr, epi_pkg::FLAG_OFS) ||
        wr_sel(wr_acc, paddr, epi_pkg::CLEAR_OFS)) begin
      wr_clear = wr_clear | {pwdata[epi_pkg::EN1_POS],
                             pwdata[epi_pkg::EN0_POS]}; // [R16]
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_pending_flag_0 <= 1'b0;
    end else if (lvl_mode[0]) begin
      ext_pending_flag_0 <= 1'b0; // [R17]
    end else if (hit[0]) begin
      ext_pending_flag_0 <= 1'b1; // [R16] [R1]
    end else if (wr_clear[0]) begin
      ext_pending_flag_0 <= 1'b0; // [R16]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_pending_flag_1 <= 1'b0;
    end else if (lvl_mode[1]) begin
      ext_pending_flag_1 <= 1'b0; // [R17]
    end else if (hit[1]) begin
      ext_pending_flag_1 <= 1'b1; // [R16] [R1]
    end else if (wr_clear[1]) begin
      ext_pending_flag_1 <= 1'b0; // [R16]
    end
  end

  assign pend_rd = {ext_pending_flag_1, ext_pending_flag_0};

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_sense_control <= epi_pkg::epi_cfg_s'(epi_pkg::SENSE_RST);
    end else if (wr_sel(wr_acc, paddr, epi_pkg::SENSE_OFS)) begin
      interrupt_sense_control.sense1 <= epi_pkg::epi_sense_e'(
        pwdata[epi_pkg::SENSE1_POS +: 2]); // [R13]
      interrupt_sense_control.sense0 <= epi_pkg::epi_sense_e'(
        pwdata[epi_pkg::SENSE0_POS +: 2]); // [R14]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_irq_enable_reg <= epi_pkg::EN_RST;
    end else if (wr_sel(wr_acc, paddr, epi_pkg::ENABLE_OFS)) begin
      general_irq_enable_reg <= {pwdata[epi_pkg::EN1_POS],
                                 pwdata[epi_pkg::EN0_POS]}; // [R15]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_status_reg <= epi_pkg::GIE_RST;
    end else if (wr_sel(wr_acc, paddr, epi_pkg::GLOBAL_OFS)) begin
      core_status_reg <= pwdata[epi_pkg::GIE_POS];
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        epi_pkg::SENSE_OFS:
          prdata[3:0] <= interrupt_sense_control;
        epi_pkg::ENABLE_OFS: begin
          prdata[epi_pkg::EN1_POS] <= general_irq_enable_reg[1];
          prdata[epi_pkg::EN0_POS] <= general_irq_enable_reg[0];
        end
        epi_pkg::FLAG_OFS: begin
          prdata[epi_pkg::EN1_POS] <= pend_rd[1];
          prdata[epi_pkg::EN0_POS] <= pend_rd[0];
        end
        epi_pkg::GLOBAL_OFS:
          prdata[epi_pkg::GIE_POS] <= core_status_reg;
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // wake sequence: two watchdog samples, then start-up count
  always_comb begin
    next_wake_state = wake_state;
    case (wake_state)
      epi_pkg::WK_RUN: begin
        if (deep_sleep && lvl_any && wdt_edge) begin
          next_wake_state = epi_pkg::WK_CONFIRM; // [R6]
        end
      end
      epi_pkg::WK_CONFIRM: begin
        // woken by another source: drop the pending confirmation
        if (!deep_sleep) begin
          next_wake_state = epi_pkg::WK_RUN;
        end else if (wdt_edge) begin
          // noise shorter than two samples is dropped
          next_wake_state = lvl_any ? epi_pkg::WK_START
                                    : epi_pkg::WK_RUN; // [R6]
        end
      end
      epi_pkg::WK_START: begin
        if (start_cnt == 16'h0000) begin
          next_wake_state = epi_pkg::WK_RUN;
        end
      end
      default: next_wake_state = epi_pkg::WK_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_state <= epi_pkg::WK_RUN;
    end else begin
      wake_state <= next_wake_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_cnt <= 16'h0000;
    end else if (next_wake_state == epi_pkg::WK_START &&
                 wake_state != epi_pkg::WK_START) begin
      // loaded one short: the exit decision takes the last cycle
      start_cnt <= epi_pkg::STARTUP_CYC - 16'h0001;
    end else if (start_cnt != 16'h0000) begin
      start_cnt <= start_cnt - 16'h0001;
    end
  end

  // wake stays up even if the level drops during start-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_wake <= 1'b0;
    end else begin
      cpu_wake <= (next_wake_state == epi_pkg::WK_START); // [R7]
    end
  end

  // one-cycle pulse on the edge that leaves start-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_done <= 1'b0;
    end else begin
      wake_done <= (wake_state == epi_pkg::WK_START) &&
                   (next_wake_state == epi_pkg::WK_RUN); // [R6]
    end
  end

  // no level request until start-up has finished
  assign lvl_mask = (wake_state != epi_pkg::WK_RUN); // [R7] [R8]

  // requests gated by global and per-input enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 2'b00;
    end else begin
      irq_req <= {2{core_status_reg}} & general_irq_enable_reg &
                 ((lvl_low & {2{~lvl_mask}}) | pend_rd); // [R9] [R2]
    end
  end

  // or of registered requests: no extra flop, so no extra latency
  assign irq = |irq_req;

endmodule // epi_top

`default_nettype wire

// ---- testbench/epi_src_model.sv ----
// far-side drivers of the two interrupt pins
`timescale 1ns/10ps
`default_nettype none

module epi_src_model (
  input  wire logic      pclk,
  output var  logic[1:0] pin
);
  initial pin = 2'h3;
  // every level is kept two clocks, so no edge is too short
  task automatic hold(input int i, input logic v);
    @(posedge pclk);
    pin[i] <= v;
    repeat (2) @(posedge pclk);
  endtask
endmodule // epi_src_model

`default_nettype wire

// ---- testbench/epi_top_assertions.sv ----
// port checker of the pin interrupt unit
`timescale 1ns/10ps
`default_nettype none

module epi_top_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        ext_irq_in_0,
  input wire logic        ext_irq_in_1,
  input wire logic        io_clk_run,
  input wire logic [1:0]  irq_req,
  input wire logic        irq,
  input wire logic        level_wake_async,
  input wire logic        cpu_wake,
  input wire logic        wake_done
);
  logic [3:0] sn;
  logic [1:0] en;
  logic       ge;
  // shadow of the config, written at the same edge as the design
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sn <= epi_pkg::SENSE_RST;
      en <= epi_pkg::EN_RST;
      ge <= epi_pkg::GIE_RST;
    end else if (psel && penable && pwrite) begin
      if (paddr == epi_pkg::SENSE_OFS) sn <= pwdata[3:0];
      if (paddr == epi_pkg::ENABLE_OFS) en <= pwdata[7:6];
      if (paddr == epi_pkg::GLOBAL_OFS) ge <= pwdata[7];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  irq_or_a:
    assert property (irq == |irq_req) else $error("irq not or");
  gate_req_a:
    assert property ($rose(irq_req[0]) |-> $past(ge && en[0]))
    else $error("request while masked");
  wake_async_a:
    assert property (level_wake_async |-> (!ext_irq_in_0 && en[0] &&
      sn[1:0] == 2'h0) || (!ext_irq_in_1 && en[1] && sn[3:2] == 2'h0))
    else $error("bad wake");
  wake_len_a:
    assert property ($rose(cpu_wake) |-> ##[63:65] wake_done)
    else $error("start-up length");
  done_pulse_a:
    assert property (wake_done |-> !cpu_wake && $past(cpu_wake))
    else $error("done without wake");
  wake_mask_a:
    assert property (cpu_wake && $past(cpu_wake, 2) && sn[1:0] == 2'h0
      |-> !irq_req[0]) else $error("request in start-up");
  io_stop_a:
    assert property ((!io_clk_run)[*5] ##0 (sn[1:0] != 2'h0)
      |-> !$rose(irq_req[0])) else $error("edge without clock");
  bad_addr_a:
    assert property (psel && penable && paddr > epi_pkg::CLEAR_OFS
      |-> pslverr) else $error("no slverr");
  cover property ($rose(cpu_wake));
  cover property ($rose(irq_req[1]));
  cover property (pslverr);
  cover property (wake_done);
endmodule // epi_top_assertions

`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench of the pin interrupt unit
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pin;
  wire         ext_irq_in_0 = pin[0];
  wire         ext_irq_in_1 = pin[1];
  logic        io_clk_run = 1'b1;
  logic        deep_sleep = 1'b0;
  logic        wdt_clk_in = 1'b0;
  logic [1:0]  vector_ack = 2'h0;
  logic [1:0]  irq_req;
  logic        irq;
  logic        level_wake_async;
  logic        cpu_wake;
  logic        wake_done;
  logic [31:0] rd;
  logic        err;
  int          bad_count = 0;
  int          num_checks = 0;

  epi_top epi_top_inst (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .ext_irq_in_0     (ext_irq_in_0),
    .ext_irq_in_1     (ext_irq_in_1),
    .io_clk_run       (io_clk_run),
    .deep_sleep       (deep_sleep),
    .wdt_clk_in       (wdt_clk_in),
    .vector_ack       (vector_ack),
    .irq_req          (irq_req),
    .irq              (irq),
    .level_wake_async (level_wake_async),
    .cpu_wake         (cpu_wake),
    .wake_done        (wake_done)
  );
  epi_src_model src (.pclk(pclk), .pin(pin));
  always #10 pclk = ~pclk;

  task automatic chk(input string s, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    chk("pready", 32'h0000_0001, 32'(pready));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string s, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(s, e, rd);
  endtask
  task automatic wait_req(input int i, input logic e);
    int n;
    n = 0;
    do @(negedge pclk); while (irq_req[i] !== e && ++n < 30);
    chk("irq_req", 32'(e), 32'(irq_req[i]));
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic wdt();
    repeat (epi_pkg::WDT_PERIOD_CYC / 2) @(posedge pclk);
    wdt_clk_in <= 1'b1;
    repeat (epi_pkg::WDT_PERIOD_CYC / 2) @(posedge pclk);
    wdt_clk_in <= 1'b0;
  endtask
  task automatic t_regs();
    rdc("sense", epi_pkg::SENSE_OFS, 32'h0000_0000);
    wr(epi_pkg::SENSE_OFS, 32'h0000_000d);
    rdc("sense", epi_pkg::SENSE_OFS, 32'h0000_000d);
    wr(epi_pkg::ENABLE_OFS, 32'hffff_ffff);
    rdc("enable", epi_pkg::ENABLE_OFS, 32'h0000_00c0);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, 32'(err));
  endtask
  task automatic t_edge(input int i, input epi_pkg::epi_sense_e m);
    logic [31:0] b;
    b = 32'h0000_0040 << i;
    wr(epi_pkg::SENSE_OFS, 32'(m) << (2 * i));
    wr(epi_pkg::GLOBAL_OFS, 32'h0000_0080);
    wr(epi_pkg::ENABLE_OFS, b);
    src.hold(i, 1'b0);
    idle(6);
    chk("fall", 32'(m != epi_pkg::SENSE_RISE), 32'(irq_req[i]));
    wr(epi_pkg::FLAG_OFS, b);
    wait_req(i, 1'b0);
    src.hold(i, 1'b1);
    idle(6);
    chk("rise", 32'(m != epi_pkg::SENSE_FALL), 32'(irq_req[i]));
    rdc("flag", epi_pkg::FLAG_OFS, m == epi_pkg::SENSE_FALL ? 0 : b);
    wr(epi_pkg::CLEAR_OFS, b);
    wait_req(i, 1'b0);
  endtask
  task automatic t_gate();
    wr(epi_pkg::SENSE_OFS, 32'h0000_0002);
    wr(epi_pkg::GLOBAL_OFS, 32'h0000_0000);
    wr(epi_pkg::ENABLE_OFS, 32'h0000_0040);
    src.hold(0, 1'b0);
    src.hold(0, 1'b1);
    idle(6);
    chk("masked", 32'h0000_0000, 32'(irq));
    wr(epi_pkg::GLOBAL_OFS, 32'h0000_0080);
    wait_req(0, 1'b1);
    @(posedge pclk);
    vector_ack <= 2'h1;
    @(posedge pclk);
    vector_ack <= 2'h0;
    wait_req(0, 1'b0);
  endtask
  task automatic t_level();
    wr(epi_pkg::SENSE_OFS, 32'h0000_0000);
    src.hold(0, 1'b0);
    wait_req(0, 1'b1);
    rdc("flag", epi_pkg::FLAG_OFS, 32'h0000_0000);
    idle(20);
    chk("held", 32'h0000_0001, 32'(irq_req[0]));
    chk("async", 32'h0000_0001, 32'(level_wake_async));
    src.hold(0, 1'b1);
    wait_req(0, 1'b0);
    wr(epi_pkg::SENSE_OFS, 32'h0000_0002);
    io_clk_run <= 1'b0;
    src.hold(0, 1'b0);
    src.hold(0, 1'b1);
    idle(8);
    @(posedge pclk);
    io_clk_run <= 1'b1;
    idle(8);
    chk("no clock", 32'h0000_0000, 32'(irq_req[0]));
  endtask
  task automatic t_wake();
    int n;
    n = 0;
    wr(epi_pkg::SENSE_OFS, 32'h0000_0000);
    deep_sleep <= 1'b1;
    src.hold(0, 1'b0);
    wdt();
    @(negedge pclk);
    chk("one sample", 32'h0000_0000, 32'(cpu_wake));
    wdt();
    idle(8);
    chk("wake", 32'h0000_0001, 32'(cpu_wake));
    chk("masked wake", 32'h0000_0000, 32'(irq_req[0]));
    src.hold(0, 1'b1);
    do @(negedge pclk); while (wake_done !== 1'b1 && ++n < 100);
    chk("done", 32'h0000_0001, 32'(wake_done));
    idle(4);
    chk("no req", 32'h0000_0000, 32'(irq_req[0]));
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    for (int i = 0; i < 2; i++)
      for (int m = 1; m < 4; m++)
        t_edge(i, epi_pkg::epi_sense_e'(m));
    t_gate();
    t_level();
    t_wake();
    results();
  end
  // whole run is near 500 cycles
  initial begin
    #400000;
    bad_count++;
    results();
  end
endmodule // tb

bind epi_top epi_top_assertions epi_top_assertions_inst (
  .pclk             (pclk),
  .presetn          (presetn),
  .psel             (psel),
  .penable          (penable),
  .pwrite           (pwrite),
  .paddr            (paddr),
  .pwdata           (pwdata),
  .pslverr          (pslverr),
  .ext_irq_in_0     (ext_irq_in_0),
  .ext_irq_in_1     (ext_irq_in_1),
  .io_clk_run       (io_clk_run),
  .irq_req          (irq_req),
  .irq              (irq),
  .level_wake_async (level_wake_async),
  .cpu_wake         (cpu_wake),
  .wake_done        (wake_done)
);

`default_nettype wire
